// ### src/xport_ctl.sv
// Purpose: reset sequencer and bussed expansion port of one repeater chip
// Assumes: all chips and the arbiter share REF_CLK; inputs are synchronous
// Notes: bus cycles are BUS_CYCLE_CYC clocks; pins use active-low enables
//
// Behaviour
// RL1: Held in reset while reset pin low
// RL2: Host holds reset 150 us at power-up; the bench holds it 3020 clocks, about 12 us
// RL3: Host holds reset 4 us later
// RL4: Stay in reset after reset pin rises
// RL5: Reset drives outputs to inactive levels
// RL6: Internal reset pulse has guaranteed length
// RL7: All chips reset together, clock synchronous
// RL8: Host keeps serial input high after reset
// RL9: Reset defaults: standard reconnect, link fail
// RL10: All chips share one common clock
// RL11: Send repeated data NRZ, one bit per cycle
// RL12: Request bus while active repeater
// RL13: Drive jam high during collision jam
// RL14: Data high one port, low several ports
// RL15: Runt signals one-port-left one cycle, then release
// RL16: Arbiter grants when exactly one requests
// RL17: Arbiter flags collision for several requesters
// RL18: Multi-active collision input means collision
// RL19: Transition cycle leaves lines undriven, keep jamming
// RL20: Afterwards only the survivor drives lines
// RL21: Non-repeater survivor keeps jam until release
// RL22: Bus cycle from common crystal clock
// RL23: Request, grant, collision pins active low
`timescale 1ns/1ns
module xport_ctl
   import xport_pkg::*;
(
   // Clock and reset
   input wire logic REF_CLK,
   input wire logic SYS_RST,
   // Reset pin, active low, synchronous to REF_CLK
   input wire logic RST_PIN_N,
   // Repeater core side
   input wire logic CORE_ACTIVE,
   input wire logic CORE_DATA,
   input wire logic CORE_COLL,
   input wire logic CORE_MULTI_PORT,
   input wire logic CORE_RUNT,
   // Expansion port pins
   output logic REQ_N,
   input wire logic GRANT_N,
   input wire logic MULTI_COL_N,
   input wire logic XDATA_IN,
   output logic XDATA_OUT,
   output logic XDATA_OE_N,
   input wire logic JAM_IN,
   output logic JAM_OUT,
   output logic JAM_OE_N,
   // Status to the repeater core
   output logic CHIP_RESET,
   output logic BUS_COLLISION,
   output logic RX_DATA,
   output logic RX_JAM,
   output logic STROBE_LINE,
   output logic SERIAL_OUT,
   output logic STD_RECONNECT,
   output logic LINK_TEST_EN,
   output logic POLARITY_FIX_EN
);
   import xport_pkg::*;

   typedef struct packed {
      logic rst_seen;
      logic [CNT_W-1:0] hold_cnt;
      logic in_reset;
      xstate_type st;
      logic [CNT_W-1:0] bus_cnt;
      logic req_n;
      logic xd_out;
      logic xd_oe_n;
      logic jam_out;
      logic jam_oe_n;
      logic bus_col;
      logic rx_data;
      logic rx_jam;
      logic [CNT_W-1:0] hi_cnt;
      logic [CNT_W-1:0] runt_cnt;
   } state_type;

   state_type s_reg;
   state_type s_next;

   // True on the last clock of an expansion bus cycle
   function automatic logic bus_edge(input logic [CNT_W-1:0] cnt);
      return cnt == BUS_LAST;
   endfunction : bus_edge

   logic grant;
   logic multi_col;
   assign grant = ~GRANT_N;
   assign multi_col = ~MULTI_COL_N;

   always_comb begin
      s_next = s_reg;
      s_next.rx_data = XDATA_IN;
      s_next.rx_jam = JAM_IN;
      // Checker helpers: clocks with reset pin high, clocks spent in runt
      if (!RST_PIN_N) begin
         s_next.hi_cnt = '0;
      end else if (s_reg.hi_cnt != 8'hFF) begin
         s_next.hi_cnt = s_reg.hi_cnt + 8'h01;
      end
      s_next.runt_cnt = (s_reg.st == ST_RUNT) ? s_reg.runt_cnt + 8'h01 : 8'h00;
      // RL1 reset pin level
      if (!RST_PIN_N) begin
         s_next.rst_seen = 1'b1;
         s_next.in_reset = 1'b1;
         s_next.hold_cnt = '0;
      end else if (s_reg.in_reset) begin
         // RL4 RL6 release hold-off; also sets a floor on internal pulse length
         if (s_reg.hold_cnt >= HOLD_LAST && s_reg.hold_cnt >= PULSE_LAST) begin
            s_next.in_reset = 1'b0;
         end else begin
            s_next.hold_cnt = s_reg.hold_cnt + 8'h01;
         end
      end
      // RL22 bus cycle divider
      s_next.bus_cnt = bus_edge(s_reg.bus_cnt) ? '0 : s_reg.bus_cnt + 8'h01;
      if (s_next.in_reset) begin
         // RL5 inactive outputs in reset
         s_next.st = ST_IDLE;
         s_next.req_n = 1'b1;
         s_next.xd_oe_n = 1'b1;
         s_next.jam_oe_n = 1'b1;
         s_next.xd_out = 1'b0;
         s_next.jam_out = 1'b0;
         s_next.bus_col = 1'b0;
      end else if (bus_edge(s_reg.bus_cnt)) begin
         // RL18 collision input
         s_next.bus_col = multi_col || CORE_COLL;
         case (s_reg.st)
            ST_IDLE: begin
               if (CORE_ACTIVE) begin
                  s_next.st = ST_ACTIVE;
               end
            end
            ST_ACTIVE: begin
               if (CORE_RUNT) begin
                  s_next.st = ST_RUNT;
               end else if (!CORE_ACTIVE) begin
                  s_next.st = ST_IDLE;
               end else if (multi_col) begin
                  s_next.st = ST_MULTI;
               end
            end
            ST_MULTI: begin
               if (!CORE_ACTIVE) begin
                  s_next.st = ST_IDLE;
               end else if (grant && !multi_col) begin
                  s_next.st = ST_TRANS;
               end
            end
            ST_TRANS: begin
               // RL19 one undriven cycle
               s_next.st = CORE_ACTIVE ? ST_ACTIVE : ST_IDLE;
            end
            ST_RUNT: begin
               // RL15 one cycle then withdraw
               s_next.st = ST_IDLE;
            end
            default: begin
               s_next.st = ST_IDLE;
            end
         endcase
         // RL12 request while active
         s_next.req_n = !(s_next.st != ST_IDLE);
         // RL20 only granted survivor drives
         // Grant only counts once our own request was already on the pin
         s_next.xd_oe_n = !((s_next.st == ST_ACTIVE || s_next.st == ST_RUNT) && grant
                            && !s_reg.req_n);
         s_next.jam_oe_n = s_next.xd_oe_n;
         if (s_next.st == ST_RUNT) begin
            // RL15 one-port-left flag
            s_next.jam_out = 1'b1;
            s_next.xd_out = 1'b1;
         end else if (CORE_COLL || s_next.st == ST_TRANS || s_next.st == ST_MULTI) begin
            // RL13 RL14 jam with port count
            s_next.jam_out = 1'b1;
            s_next.xd_out = !CORE_MULTI_PORT;
         end else begin
            s_next.jam_out = 1'b0;
            s_next.xd_out = CORE_DATA;
         end
      end else if (!s_reg.xd_oe_n && !s_reg.jam_out) begin
         // RL11 NRZ bit per clock while driving
         s_next.xd_out = CORE_DATA;
      end
   end

   // RL10 one shared clock
   always_ff @(posedge REF_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         s_reg <= '{rst_seen: 1'b0, hold_cnt: '0, in_reset: 1'b1, st: ST_IDLE,
                    bus_cnt: '0, req_n: 1'b1, xd_out: 1'b0, xd_oe_n: 1'b1,
                    jam_out: 1'b0, jam_oe_n: 1'b1, bus_col: 1'b0,
                    rx_data: 1'b0, rx_jam: 1'b0, hi_cnt: '0, runt_cnt: '0};
      end else begin
         s_reg <= s_next;
      end
   end

   // RL23 active-low pins
   assign REQ_N = s_reg.req_n;
   assign XDATA_OUT = s_reg.xd_out;
   assign XDATA_OE_N = s_reg.xd_oe_n;
   assign JAM_OUT = s_reg.jam_out;
   assign JAM_OE_N = s_reg.jam_oe_n;
   assign CHIP_RESET = s_reg.in_reset;
   assign BUS_COLLISION = s_reg.bus_col;
   assign RX_DATA = s_reg.rx_data;
   assign RX_JAM = s_reg.rx_jam;
   // RL5 strobe low, serial out high; RL9 reset defaults
   assign STROBE_LINE = 1'b0;
   assign SERIAL_OUT = 1'b1;
   assign STD_RECONNECT = 1'b1;
   assign LINK_TEST_EN = 1'b1;
   assign POLARITY_FIX_EN = 1'b0;

   property p_hold;
      @(posedge REF_CLK) disable iff (SYS_RST)
      $rose(RST_PIN_N) |-> CHIP_RESET [*8];
   endproperty
   a_hold: assert property (p_hold) else $error("reset released early"); // RL4

   property p_pinrst;
      @(posedge REF_CLK) disable iff (SYS_RST)
      !RST_PIN_N |=> CHIP_RESET && REQ_N && XDATA_OE_N && JAM_OE_N;
   endproperty
   a_pinrst: assert property (p_pinrst) else $error("outputs active in reset"); // RL5

   property p_release;
      @(posedge REF_CLK) disable iff (SYS_RST)
      (s_reg.hi_cnt > HOLD_LAST) |-> !CHIP_RESET;
   endproperty
   a_release: assert property (p_release) else $error("reset never released"); // RL4

   property p_hold_cnt;
      @(posedge REF_CLK) disable iff (SYS_RST)
      (s_reg.hi_cnt <= HOLD_LAST) |-> CHIP_RESET;
   endproperty
   a_hold_cnt: assert property (p_hold_cnt) else $error("internal reset too short"); // RL6

   sequence s_driving;
      !JAM_OE_N && JAM_OUT;
   endsequence
   property p_jamdat;
      @(posedge REF_CLK) disable iff (SYS_RST)
      s_driving ##0 ($rose(JAM_OUT) && s_reg.st != ST_RUNT)
         |-> XDATA_OUT == !$past(CORE_MULTI_PORT);
   endproperty
   a_jamdat: assert property (p_jamdat) else $error("jam data wrong"); // RL14

   property p_nodrive_idle;
      @(posedge REF_CLK) disable iff (SYS_RST)
      REQ_N |-> XDATA_OE_N;
   endproperty
   a_nodrive_idle: assert property (p_nodrive_idle) else $error("drive without request"); // RL12

   property p_trans;
      @(posedge REF_CLK) disable iff (SYS_RST)
      (s_reg.st == ST_TRANS) |-> XDATA_OE_N && JAM_OE_N && !REQ_N;
   endproperty
   a_trans: assert property (p_trans) else $error("transition cycle driven"); // RL19

   property p_runt;
      @(posedge REF_CLK) disable iff (SYS_RST)
      $fell(s_reg.st == ST_RUNT) |-> REQ_N && $past(s_reg.runt_cnt) == BUS_LAST;
   endproperty
   a_runt: assert property (p_runt) else $error("runt flag length wrong"); // RL15

   property p_runt_max;
      @(posedge REF_CLK) disable iff (SYS_RST)
      (s_reg.st == ST_RUNT) |-> s_reg.runt_cnt <= BUS_LAST;
   endproperty
   a_runt_max: assert property (p_runt_max) else $error("runt flag held too long"); // RL15

   property p_nogrant;
      @(posedge REF_CLK) disable iff (SYS_RST)
      $fell(XDATA_OE_N) |-> $past(grant && !REQ_N);
   endproperty
   a_nogrant: assert property (p_nogrant) else $error("drive without grant"); // RL20
endmodule : xport_ctl

// ### pkg/xport_pkg.sv
// Purpose: constants for the repeater reset sequencer and expansion port
// Assumes: one common 250 MHz reference clock shared by all chips
// Notes: all timing counts derive from printed times and the clock period
package xport_pkg;
   localparam int CLK_PERIOD_PS = 4000;
   // Hold-off after reset input rises, in nanoseconds
   localparam int RST_HOLD_NS = 500;
   localparam int RST_HOLD_CYC = (RST_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   // Expansion bus cycle, in nanoseconds
   localparam int BUS_CYCLE_NS = 100;
   localparam int BUS_CYCLE_CYC = (BUS_CYCLE_NS * 1000) / CLK_PERIOD_PS;
   // Least internal reset pulse, in nanoseconds
   localparam int MIN_PULSE_NS = 500;
   localparam int MIN_PULSE_CYC = (MIN_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int CNT_W = 8;
   localparam logic [CNT_W-1:0] HOLD_LAST = 8'(RST_HOLD_CYC - 1);
   localparam logic [CNT_W-1:0] PULSE_LAST = 8'(MIN_PULSE_CYC - 1);
   localparam logic [CNT_W-1:0] BUS_LAST = 8'(BUS_CYCLE_CYC - 1);

   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_ACTIVE = 5'h02,
      ST_MULTI = 5'h04,
      ST_TRANS = 5'h08,
      ST_RUNT = 5'h10
   } xstate_type;
endpackage : xport_pkg

// ### tb/xarb_model.sv
// Purpose: external arbiter and shared bus lines beside one chip
// Assumes: requests are synchronous to the common REF_CLK
// Notes: undriven bus lines settle to the pull-down level
`timescale 1ns/1ns
module xarb_model (
   // Requests, active low
   input wire logic req_a_n,
   input wire logic req_b_n,
   // Drivers onto the bus
   input wire logic xd,
   input wire logic xd_oe_n,
   input wire logic jm,
   input wire logic jm_oe_n,
   // Jam from a lone non-repeater agent
   input wire logic ag_jm,
   // Arbiter outputs and line levels
   output logic grant_n,
   output logic col_n,
   output logic xd_line,
   output logic jm_line
);
   assign grant_n = ~(req_a_n ^ req_b_n);
   assign col_n = ~(grant_n & (~req_a_n | ~req_b_n));
   assign xd_line = xd_oe_n ? 1'b0 : xd;
   // survivor agent may hold jam while the chip is off the line
   assign jm_line = jm_oe_n ? ag_jm : jm;
endmodule : xarb_model

// ### tb/tb_top.sv
// Purpose: self-checking bench for the reset and expansion port logic
// Assumes: a second chip is modelled by one request line and one jam line
// Notes: inputs change on the falling edge
`timescale 1ns/1ns
module tb_top;
   import xport_pkg::*;
   logic clk = 1'b0, rst = 1'b1, rpin_n = 1'b0, act = 1'b0, dat = 1'b0;
   logic coll = 1'b0, mport = 1'b0, runt = 1'b0, oreq_n = 1'b1, ag_jm = 1'b0;
   logic req_n, gnt_n, col_n, xdi, xdo, xdoe_n, jmi, jmo, jmoe_n, crst;
   logic bcol, strb, so, stdr, lte, pfe, rxd, rxj;
   int failures = 0, cmp_count = 0, cyc = 0, n;
   always #2 clk = ~clk;
   xport_ctl xport_ctl_i (.REF_CLK(clk), .SYS_RST(rst), .RST_PIN_N(rpin_n),
      .CORE_ACTIVE(act), .CORE_DATA(dat), .CORE_COLL(coll), .CORE_MULTI_PORT(mport),
      .CORE_RUNT(runt), .REQ_N(req_n), .GRANT_N(gnt_n), .MULTI_COL_N(col_n),
      .XDATA_IN(xdi), .XDATA_OUT(xdo), .XDATA_OE_N(xdoe_n), .JAM_IN(jmi),
      .JAM_OUT(jmo), .JAM_OE_N(jmoe_n), .CHIP_RESET(crst), .BUS_COLLISION(bcol),
      .RX_DATA(rxd), .RX_JAM(rxj), .STROBE_LINE(strb), .SERIAL_OUT(so),
      .STD_RECONNECT(stdr), .LINK_TEST_EN(lte), .POLARITY_FIX_EN(pfe));
   xarb_model xarb_model_i (.req_a_n(req_n), .req_b_n(oreq_n), .xd(xdo),
      .xd_oe_n(xdoe_n), .jm(jmo), .jm_oe_n(jmoe_n), .grant_n(gnt_n),
      .col_n(col_n), .xd_line(xdi), .jm_line(jmi), .ag_jm(ag_jm));
   task automatic check(input logic seen, input logic exp);
      cmp_count++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic tk(input int k);
      repeat (k) @(negedge clk);
   endtask : tk
   task automatic t_reset(input int low);
      rpin_n = 1'b0;
      tk(low);
      check(crst, 1'b1);
      check(req_n, 1'b1);
      check(xdoe_n & jmoe_n, 1'b1);
      check(strb, 1'b0);
      check(so, 1'b1);
      check(stdr & lte & ~pfe, 1'b1);
      // serial input is outside this block and idles high
      rpin_n = 1'b1;
      for (n = 0; n < 300 && crst !== 1'b0; n++) tk(1);
      check(n >= 125 && n <= 127, 1'b1);
      $display("reset test done");
   endtask : t_reset
   task automatic t_single;
      act = 1'b1;
      for (n = 0; n < 60 && req_n !== 1'b0; n++) tk(1);
      check(req_n, 1'b0);
      for (n = 0; n < 60 && xdoe_n !== 1'b0; n++) tk(1);
      check(xdoe_n, 1'b0);
      repeat (4) begin
         dat = ~dat;
         tk(1);
         check(xdo, dat);
         check(jmi, 1'b0);
      end
      $display("single test done");
   endtask : t_single
   task automatic t_coll;
      coll = 1'b1;
      for (n = 0; n < 60 && jmi !== 1'b1; n++) tk(1);
      check(jmi, 1'b1);
      check(xdi, 1'b1);
      mport = 1'b1;
      tk(30);
      check(xdi, 1'b0);
      check(rxd, 1'b0);
      check(rxj, 1'b1);
      check(bcol, 1'b1);
      coll = 1'b0;
      mport = 1'b0;
      tk(30);
      $display("collision test done");
   endtask : t_coll
   task automatic t_multi;
      oreq_n = 1'b0;
      tk(30);
      check(bcol, 1'b1);
      check(xdoe_n | jmoe_n, 1'b1);
      oreq_n = 1'b1;
      for (n = 0; n < 100 && xdoe_n !== 1'b0; n++) tk(1);
      check(n >= 24 && n <= 60, 1'b1);
      check(jmoe_n, 1'b0);
      $display("multi test done");
   endtask : t_multi
   task automatic t_runt;
      runt = 1'b1;
      for (n = 0; n < 60 && jmi !== 1'b1; n++) tk(1);
      check(xdi, 1'b1);
      runt = 1'b0;
      act = 1'b0;
      for (n = 0; n < 100 && req_n !== 1'b1; n++) tk(1);
      check(n >= 20 && n <= 30, 1'b1);
      $display("runt test done");
   endtask : t_runt
   task automatic t_agent;
      act = 1'b1;
      oreq_n = 1'b0;
      tk(60);
      check(bcol, 1'b1);
      check(xdoe_n & jmoe_n, 1'b1);
      act = 1'b0;
      ag_jm = 1'b1;
      tk(30);
      check(req_n, 1'b1);
      check(xdoe_n, 1'b1);
      check(rxj, 1'b1);
      oreq_n = 1'b1;
      ag_jm = 1'b0;
      tk(30);
      check(rxj, 1'b0);
      $display("agent test done");
   endtask : t_agent
   task automatic tally_and_finish;
      $display("compares=%0d mismatches=%0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : tally_and_finish
   // Ceiling well above the planned run of about 5000 clocks
   always @(posedge clk) begin
      cyc++;
      if (cyc == 12000) begin
         failures++;
         tally_and_finish();
      end
   end
   initial begin
      tk(20);
      rst = 1'b0;
      // power-up reset, applied on the shared clock
      t_reset(3000);
      t_single();
      t_coll();
      t_multi();
      t_runt();
      t_agent();
      t_reset(1000);
      tally_and_finish();
   end
endmodule : tb_top
